/* File: hdl/rc_trim_pkg.sv */
// package: register map, field layout and reset values of the oscillator trim select block
package rc_trim_pkg;

    // ----------------------------------------------------------------
    // register offsets (byte addresses on the apb)
    // ----------------------------------------------------------------
    localparam logic [7:0] user_trim_off = 8'h00;           // user trim and sequencing enable
    localparam logic [7:0] tune_sequence_upper_off = 8'h04; // entries four to seven
    localparam logic [7:0] pseudo_random_trim_off = 8'h08;  // 15-bit pseudo-random trim
    localparam logic [7:0] trim_status_off = 8'h0c;         // applied trim, read only

    // ----------------------------------------------------------------
    // field layout
    // ----------------------------------------------------------------
    localparam int seq_four_lsb = 0;    // entry four at bits 3:0
    localparam int seq_five_lsb = 4;    // entry five at bits 7:4
    localparam int seq_six_lsb = 8;     // entry six at bits 11:8
    localparam int seq_seven_lsb = 12;  // entry seven at bits 15:12
    localparam int seq_enable_bit = 4;  // sequencing enable in the user trim register
    localparam logic [15:0] prt_write_mask = 16'h7fff; // top bit not implemented

    // ----------------------------------------------------------------
    // reset values
    // ----------------------------------------------------------------
    localparam logic [15:0] tune_sequence_upper_rst = 16'h0000;
    localparam logic [15:0] pseudo_random_trim_rst = 16'h0000;
    localparam logic [3:0] user_trim_rst = 4'h0;

    // roll selector codes that pick an upper entry
    localparam logic [2:0] roll_four = 3'h4;
    localparam logic [2:0] roll_five = 3'h5;
    localparam logic [2:0] roll_six = 3'h6;
    localparam logic [2:0] roll_seven = 3'h7;

    // apb request carried as one bundle
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [7:0] paddr;
        logic [31:0] pwdata;
    } apb_req_t;

endpackage : rc_trim_pkg

/* File: hdl/rc_osc_trim_sequence_select.sv */
// module: trim value selection for the internal fast rc oscillator, apb register slave
//
// Local design decisions: the address map and the APB register port.
`timescale 1ns/1ps
`default_nettype none

module rc_osc_trim_sequence_select (
    input wire logic clk,
    input wire logic rst,
    input wire rc_trim_pkg::apb_req_t apb_req,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [2:0] roll_sel,
    output logic [3:0] osc_trim,
    output logic [14:0] pseudo_random_trim_value
);

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    logic [15:0] tune_sequence_upper_q; // entries four..seven as written
    logic [15:0] tune_sequence_upper_d; // next value of the sequence entries
    logic [15:0] pseudo_random_trim_q; // 15 bits used, bit 15 always zero
    logic [15:0] pseudo_random_trim_d; // next value of the pseudo-random trim
    logic [3:0] user_trim_q; // fallback trim
    logic [3:0] user_trim_d; // next fallback trim
    logic seq_en_q; // sequencing enable
    logic seq_en_d; // next sequencing enable
    logic [2:0] roll_s1_q; // roll synchroniser, first stage
    logic [2:0] roll_s1_d; // first stage input
    logic [2:0] roll_s2_q; // roll synchroniser, second stage
    logic [2:0] roll_s2_d; // second stage input
    logic [2:0] roll_s3_q; // delayed copy used only for the agreement test
    logic [2:0] roll_s3_d; // third stage input
    logic [2:0] roll_hold_q; // last roll code seen steady for two samples
    logic [2:0] roll_hold_d; // next accepted roll code
    logic [3:0] trim_q; // applied trim
    logic [3:0] trim_d; // next applied trim
    logic [31:0] prdata_q; // read data flop
    logic [31:0] prdata_d; // next read data
    logic wr_acc; // write strobe in the access cycle
    logic rd_acc; // read strobe in the setup cycle
    logic mapped; // address decodes to a register

    // the slave answers in the first access cycle: no wait states
    // every register is a plain flop, so nothing ever needs a wait state;
    // the price is that read data must be picked in the setup cycle
    assign pready = apb_req.psel & apb_req.penable;
    assign wr_acc = pready & apb_req.pwrite;
    assign rd_acc = apb_req.psel & ~apb_req.penable & ~apb_req.pwrite;

    // decode used only by the error answer; the read mux decodes the address itself
    function automatic logic is_mapped(input logic [7:0] a);
        is_mapped = (a == rc_trim_pkg::user_trim_off) |
                    (a == rc_trim_pkg::tune_sequence_upper_off) |
                    (a == rc_trim_pkg::pseudo_random_trim_off) |
                    (a == rc_trim_pkg::trim_status_off);
    endfunction : is_mapped

    assign mapped = is_mapped(apb_req.paddr);
    // unmapped addresses answer with an error, writes there are dropped
    assign pslverr = pready & ~mapped;

    // ----------------------------------------------------------------
    // register writes
    // ----------------------------------------------------------------
    always_comb begin
        tune_sequence_upper_d = tune_sequence_upper_q;
        pseudo_random_trim_d = pseudo_random_trim_q;
        user_trim_d = user_trim_q;
        seq_en_d = seq_en_q;
        if (wr_acc) begin
            case (apb_req.paddr)
                rc_trim_pkg::user_trim_off: begin
                    user_trim_d = apb_req.pwdata[3:0];
                    seq_en_d = apb_req.pwdata[rc_trim_pkg::seq_enable_bit];
                end
                rc_trim_pkg::tune_sequence_upper_off: begin
                    tune_sequence_upper_d = apb_req.pwdata[15:0];
                end
                rc_trim_pkg::pseudo_random_trim_off: begin
                    // bit 15 masked off so it never stores
                    pseudo_random_trim_d = apb_req.pwdata[15:0] & rc_trim_pkg::prt_write_mask;
                end
                default: begin
                    // status and unmapped: nothing stored
                end
            endcase
        end
    end

    // registers with synchronous reset to zero
    always_ff @(posedge clk) begin
        if (rst) begin
            tune_sequence_upper_q <= rc_trim_pkg::tune_sequence_upper_rst;
            pseudo_random_trim_q <= rc_trim_pkg::pseudo_random_trim_rst;
            user_trim_q <= rc_trim_pkg::user_trim_rst;
            seq_en_q <= 1'b0;
        end else begin
            tune_sequence_upper_q <= tune_sequence_upper_d;
            pseudo_random_trim_q <= pseudo_random_trim_d;
            user_trim_q <= user_trim_d;
            seq_en_q <= seq_en_d;
        end
    end

    // ----------------------------------------------------------------
    // roll selector synchroniser (pwm side may be asynchronous)
    // ----------------------------------------------------------------
    // the three roll bits are a plain binary code, not gray coded, so two
    // flops alone could pass a half-changed code for a cycle and apply a
    // wrong entry; a code is only accepted once two successive samples of
    // the second stage agree, at the price of two more cycles of latency
    always_comb begin
        roll_s1_d = roll_sel; // first stage samples the pin
        roll_s2_d = roll_s1_q; // second stage lets metastability settle
        roll_s3_d = roll_s2_q; // third stage only feeds the agreement test
        roll_hold_d = roll_hold_q; // keep the last accepted code by default
        if (roll_s2_q == roll_s3_q) begin
            roll_hold_d = roll_s2_q; // steady for two samples: accept it
        end
    end

    // synchroniser and accepted code flops, cleared by reset
    always_ff @(posedge clk) begin
        if (rst) begin
            roll_s1_q <= 3'h0;
            roll_s2_q <= 3'h0;
            roll_s3_q <= 3'h0;
            roll_hold_q <= 3'h0;
        end else begin
            roll_s1_q <= roll_s1_d;
            roll_s2_q <= roll_s2_d;
            roll_s3_q <= roll_s3_d;
            roll_hold_q <= roll_hold_d;
        end
    end

    // ----------------------------------------------------------------
    // trim selection
    // ----------------------------------------------------------------
    // codes 000..011 pick entries kept elsewhere, so they fall back here
    // only the accepted roll code is used, never a stage still settling
    always_comb begin
        trim_d = user_trim_q;
        if (seq_en_q) begin
            case (roll_hold_q)
                rc_trim_pkg::roll_four:
                    trim_d = tune_sequence_upper_q[rc_trim_pkg::seq_four_lsb +: 4];
                rc_trim_pkg::roll_five:
                    trim_d = tune_sequence_upper_q[rc_trim_pkg::seq_five_lsb +: 4];
                rc_trim_pkg::roll_six:
                    trim_d = tune_sequence_upper_q[rc_trim_pkg::seq_six_lsb +: 4];
                rc_trim_pkg::roll_seven:
                    trim_d = tune_sequence_upper_q[rc_trim_pkg::seq_seven_lsb +: 4];
                default:
                    trim_d = user_trim_q;
            endcase
        end
    end

    // applied trim is registered so the oscillator sees no glitches
    always_ff @(posedge clk) begin
        if (rst) begin
            trim_q <= rc_trim_pkg::user_trim_rst;
        end else begin
            trim_q <= trim_d;
        end
    end

    assign osc_trim = trim_q;
    assign pseudo_random_trim_value = pseudo_random_trim_q[14:0];

    // ----------------------------------------------------------------
    // read data, captured in the setup cycle, valid in the access cycle
    // ----------------------------------------------------------------
    always_comb begin
        prdata_d = 32'h0000_0000;
        if (rd_acc) begin
            case (apb_req.paddr)
                rc_trim_pkg::user_trim_off:
                    prdata_d = {27'h0, seq_en_q, user_trim_q};
                rc_trim_pkg::tune_sequence_upper_off:
                    prdata_d = {16'h0, tune_sequence_upper_q};
                rc_trim_pkg::pseudo_random_trim_off:
                    prdata_d = {17'h0, pseudo_random_trim_q[14:0]};
                rc_trim_pkg::trim_status_off:
                    // applied trim exactly as the oscillator sees it
                    prdata_d = {28'h0, trim_q};
                default:
                    prdata_d = 32'h0000_0000;
            endcase
        end else if (apb_req.psel & apb_req.penable) begin
            prdata_d = prdata_q; // hold through the access
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            prdata_q <= 32'h0000_0000;
        end else begin
            prdata_q <= prdata_d;
        end
    end

    assign prdata = prdata_q;

endmodule : rc_osc_trim_sequence_select

`default_nettype wire

/* File: test/rc_trim_monitor.sv */
// checker: port-level assertions for the oscillator trim select block
`timescale 1ns/1ps
`default_nettype none
module rc_trim_monitor (
    input wire logic clk,
    input wire logic rst,
    input wire rc_trim_pkg::apb_req_t apb_req,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [2:0] roll_sel,
    input wire logic [3:0] osc_trim,
    input wire logic [14:0] pseudo_random_trim_value
);
    logic [15:0] seq_q; // shadow of the sequence entries
    logic [4:0] user_q; // shadow of user trim and enable
    logic [14:0] wd_q; // low write data bits of the previous cycle, captured every cycle
    logic [2:0] roll_q;
    logic [2:0] calm_q; // cycles since roll or a write moved, saturating
    wire wr = apb_req.psel && apb_req.penable && apb_req.pwrite;
    wire rd = apb_req.psel && apb_req.penable && !apb_req.pwrite;
    wire [7:0] a = apb_req.paddr;
    wire prt = a == rc_trim_pkg::pseudo_random_trim_off;
    // trim is judged only once three sync stages, the agreement flop and
    // the output flop have all seen a steady roll code and steady registers
    wire settled = calm_q >= 3'h4 && roll_sel == roll_q;
    always_ff @(posedge clk) begin
        roll_q <= roll_sel;
        wd_q <= apb_req.pwdata[14:0];
        if (rst) begin
            seq_q <= 16'h0000;
            user_q <= 5'h00;
            calm_q <= 3'h0;
        end else begin
            if (wr && a == rc_trim_pkg::tune_sequence_upper_off) seq_q <= apb_req.pwdata[15:0];
            if (wr && a == rc_trim_pkg::user_trim_off) user_q <= apb_req.pwdata[4:0];
            calm_q <= (wr || roll_sel != roll_q) ? 3'h0 : calm_q + {2'h0, calm_q != 3'h7};
        end
    end
    // ----------------------------------------------------------------
    // assertions, all on the one system clock
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // sequencing on and an upper roll code: the matching entry is applied
    chk_roll_four: assert property (
        settled && user_q[4] && roll_sel == 3'h4 |-> osc_trim == seq_q[3:0])
        else $error("entry four not applied");
    chk_roll_five: assert property (
        settled && user_q[4] && roll_sel == 3'h5 |-> osc_trim == seq_q[7:4])
        else $error("entry five not applied");
    chk_roll_six: assert property (
        settled && user_q[4] && roll_sel == 3'h6 |-> osc_trim == seq_q[11:8])
        else $error("entry six not applied");
    chk_roll_seven: assert property (
        settled && user_q[4] && roll_sel == 3'h7 |-> osc_trim == seq_q[15:12])
        else $error("entry seven not applied");
    // sequencing off or a lower roll code: the user trim stays in charge
    chk_user_fallback: assert property (
        settled && !(user_q[4] && roll_sel[2]) |-> osc_trim == user_q[3:0])
        else $error("user trim not applied");
    // read data answers in the access cycle, written trim shows one cycle later
    chk_seq_readback: assert property (
        rd && a == rc_trim_pkg::tune_sequence_upper_off |-> prdata == {16'h0000, seq_q})
        else $error("sequence readback wrong");
    chk_prt_upper: assert property (
        wr && prt |=> pseudo_random_trim_value[14:8] == wd_q[14:8])
        else $error("upper trim bits not written");
    chk_prt_lower: assert property (
        wr && prt |=> pseudo_random_trim_value[7:0] == wd_q[7:0])
        else $error("lower trim bits not written");
    chk_prt_top_zero: assert property (
        rd && prt |-> !prdata[15])
        else $error("top trim bit reads one");
    // the main scenarios must each be reached at least once
    cover property (settled && user_q[4] && roll_sel == 3'h7);
    cover property (settled && !user_q[4] && roll_sel == 3'h7);
    cover property (wr && prt);
    cover property (pslverr);
endmodule : rc_trim_monitor
`default_nettype wire

/* File: test/tb_top.sv */
// testbench: register and trim selection tests for the oscillator trim select block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic clk;
    logic rst;
    rc_trim_pkg::apb_req_t req; // apb request driven by the bench
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [2:0] roll;
    logic [3:0] osc_trim;
    logic [14:0] prt_val;
    logic [31:0] q; // read data of the last transfer
    logic e; // error response of the last transfer
    logic [31:0] exp_trim; // trim expected from the sequence entries or the user trim
    int fails;
    int num_checks;
    rc_osc_trim_sequence_select u_dut (.clk(clk), .rst(rst), .apb_req(req), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .roll_sel(roll), .osc_trim(osc_trim),
        .pseudo_random_trim_value(prt_val));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fails++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    // one transfer; the request is held until pready is sampled high
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        req <= '{1'b1, 1'b0, w, a, d};
        @(posedge clk);
        req.penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        q = prdata;
        e = pslverr;
        req <= '0;
    endtask : xfer
    task automatic final_report;
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : final_report
    // watchdog: the tests need about 1.5 us
    initial begin
        #20000;
        fails++;
        final_report();
    end
    initial begin
        rst = 1'b1;
        req = '0;
        roll = 3'h0;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        xfer(1'b0, 8'h04, 32'h0);
        chk("seq reset", q, 32'h0);
        xfer(1'b0, 8'h08, 32'h0);
        chk("prt reset", q, 32'h0);
        xfer(1'b1, 8'h04, 32'hffffdcba);
        xfer(1'b0, 8'h04, 32'h0);
        chk("seq", q, 32'h0000dcba);
        xfer(1'b1, 8'h08, 32'hffffffff);
        xfer(1'b0, 8'h08, 32'h0);
        chk("prt top", q, 32'h00007fff);
        xfer(1'b1, 8'h08, 32'h00005a3c);
        xfer(1'b0, 8'h08, 32'h0);
        chk("prt", q, 32'h00005a3c);
        chk("prt port", {17'h0, prt_val}, 32'h00005a3c);
        // unmapped place answers with an error and zero data
        xfer(1'b0, 8'h10, 32'h0);
        chk("unmapped", {q[30:0], e}, 32'h1);
        for (int en = 0; en < 2; en++) begin
            xfer(1'b1, 8'h00, {27'h0, en[0], 4'h9});
            for (int r = 0; r < 8; r++) begin
                @(posedge clk);
                roll <= r[2:0];
                // three sync stages, the agreement flop and the output flop
                repeat (6) @(posedge clk);
                exp_trim = (en == 1 && r > 3) ? ((32'hdcba >> (4 * (r - 4))) & 32'hf) : 32'h9;
                chk("trim", {28'h0, osc_trim}, exp_trim);
            end
        end
        // applied trim and user trim read back while roll 111 still stands
        xfer(1'b0, 8'h0c, 32'h0);
        chk("status", q, 32'h0000000d);
        xfer(1'b0, 8'h00, 32'h0);
        chk("user trim", q, 32'h00000019);
        final_report();
    end
endmodule : tb_top
bind rc_osc_trim_sequence_select rc_trim_monitor u_mon (.clk(clk), .rst(rst), .apb_req(apb_req),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .roll_sel(roll_sel),
    .osc_trim(osc_trim), .pseudo_random_trim_value(pseudo_random_trim_value));
`default_nettype wire
